// [shared/psw_pkg.sv]
// Purpose: constants and types for the processor supervisor watchdog
// Assumes: 250 MHz clock, synchronous active-low reset
// Notes: long counts are derived from milliseconds at the clock rate
`default_nettype none
package psw_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned RESET_HOLD_MS = 250;
  localparam int unsigned DEBOUNCE_MS = 250;
  localparam int unsigned WD_SHORT_MS = 250;
  localparam int unsigned WD_MID_MS = 500;
  localparam int unsigned WD_LONG_MS = 1000;
  localparam int unsigned OSC_START_MS = 1000;
  localparam longint unsigned CYC_PER_MS = 64'(CLK_MHZ) * 64'd1000;
  localparam longint unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CYC_PER_MS;
  localparam longint unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
  localparam longint unsigned WD_SHORT_CYC = WD_SHORT_MS * CYC_PER_MS;
  localparam longint unsigned WD_MID_CYC = WD_MID_MS * CYC_PER_MS;
  localparam longint unsigned WD_LONG_CYC = WD_LONG_MS * CYC_PER_MS;
  localparam longint unsigned OSC_START_CYC = OSC_START_MS * CYC_PER_MS;
  localparam int CNT_W = 32;
  localparam logic [1:0] TD_OFF = 2'h0;
  localparam logic [1:0] TD_SHORT = 2'h1;
  localparam logic [1:0] TD_MID = 2'h2;
  localparam logic [1:0] TD_RESET = 2'h3;
  localparam logic [7:0] WDREG_RESET = 8'h03;
  typedef struct packed {
    logic sram_select_in;
    logic upper_byte_enable_in;
    logic lower_byte_enable_in;
  } psw_sram_req_type;
  typedef struct packed {
    logic upper_sram_select_out;
    logic lower_sram_select_out;
  } psw_sram_sel_type;
endpackage : psw_pkg
`default_nettype wire

// [logic/psw_sram_gate.sv]
// Purpose: gate external SRAM chip selects for word or byte access
// Assumes: selects and enables active low, blocking from supervisor
// Notes: outputs registered, one cycle latency
`default_nettype none
module psw_sram_gate
  import psw_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic block,
  input wire psw_sram_req_type req,
  // selects to SRAM
  output psw_sram_sel_type sel
);
  typedef struct packed {
    psw_sram_sel_type sel;
  } psw_gate_st_type;
  psw_gate_st_type s_q;
  psw_gate_st_type s_d;

  always_comb begin
    s_d = s_q;
    s_d.sel.upper_sram_select_out = 1'b1;
    s_d.sel.lower_sram_select_out = 1'b1;
    if (!block && !req.sram_select_in) begin
      s_d.sel.upper_sram_select_out = req.upper_byte_enable_in;
      s_d.sel.lower_sram_select_out = req.lower_byte_enable_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign sel = s_q.sel;

  property p_gate_block;
    @(posedge clk) disable iff (!nrst)
      block |=> sel == 2'b11;
  endproperty
  a_gate_block: assert property (p_gate_block)
    else $error("sram select active while blocked");

  property p_gate_pass;
    @(posedge clk) disable iff (!nrst)
      (!block && !req.sram_select_in) |=>
        sel.upper_sram_select_out == $past(req.upper_byte_enable_in) &&
        sel.lower_sram_select_out == $past(req.lower_byte_enable_in);
  endproperty
  a_gate_pass: assert property (p_gate_pass)
    else $error("sram select does not follow byte enables");
endmodule : psw_sram_gate
`default_nettype wire

// [logic/psw_wdog.sv]
// Purpose: watchdog countdown with selectable period
// Assumes: strobe synchronous to clk
// Notes: expiry is a one-cycle pulse; reset hold is done above
`default_nettype none
module psw_wdog
  import psw_pkg::*;
#(
  parameter logic [CNT_W-1:0] SHORT_CYC = CNT_W'(WD_SHORT_CYC),
  parameter logic [CNT_W-1:0] MID_CYC = CNT_W'(WD_MID_CYC),
  parameter logic [CNT_W-1:0] LONG_CYC = CNT_W'(WD_LONG_CYC)
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic [1:0] timeout_code,
  input wire logic hold,
  input wire logic watchdog_strobe,
  // event
  output logic expired
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic strobe;
    logic expired;
  } psw_wd_st_type;
  psw_wd_st_type s_q;
  psw_wd_st_type s_d;

  function automatic logic [CNT_W-1:0] period(input logic [1:0] code);
    unique case (code)
      TD_SHORT: period = SHORT_CYC;
      TD_MID: period = MID_CYC;
      default: period = LONG_CYC;
    endcase
  endfunction : period

  logic fall;
  assign fall = s_q.strobe && !watchdog_strobe;

  always_comb begin
    s_d = s_q;
    s_d.strobe = watchdog_strobe;
    s_d.expired = 1'b0;
    if (timeout_code == TD_OFF) begin
      s_d.cnt = period(timeout_code);
    end else if (hold) begin
      s_d.cnt = period(timeout_code);
    end else if (fall) begin
      s_d.cnt = period(timeout_code);
    end else if (s_q.cnt <= CNT_W'(1)) begin
      s_d.expired = 1'b1;
      s_d.cnt = period(timeout_code);
    end else begin
      s_d.cnt = s_q.cnt - CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q <= '{cnt: LONG_CYC, strobe: 1'b1, expired: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.expired;

  property p_wd_off;
    @(posedge clk) disable iff (!nrst)
      timeout_code == TD_OFF |=> !expired;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("watchdog fired while disabled");

  property p_wd_kick;
    @(posedge clk) disable iff (!nrst)
      (fall && !hold && timeout_code != TD_OFF) |=>
        s_q.cnt == period($past(timeout_code));
  endproperty
  a_wd_kick: assert property (p_wd_kick)
    else $error("strobe edge did not restart countdown");
endmodule : psw_wdog
`default_nettype wire

// [logic/psw_supervisor.sv]
// Purpose: processor supervisor: power-fail reset, pushbutton, watchdog,
//   SRAM select gating
// Assumes: power_fail and reset line inputs synchronous to clk
// Notes: reset line is open drain; reading it returns the wire level
//
// Notes on behaviour
// - chip select low passes byte enables to upper and lower selects
// - power fail forces both SRAM selects high
// - SRAM stays blocked until power-up reset delay ends
// - power fail asserts processor reset at once
// - reset held 250 ms after supply returns
// - oscillator disable adds oscillator startup time to hold
// - outside a reset cycle, watch reset line for falling edge
// - on button edge, pull line low and debounce 250 ms
// - still low: wait for release, then hold low 250 ms
// - timeout code 01, 10, 11 give 250, 500, 1000 ms
// - timeout code 00 disables the watchdog
// - countdown starts when processor reset goes inactive
// - after power-up, watchdog enabled at 1000 ms
// - strobe falling edge restarts full countdown
// - watchdog expiry asserts reset for 250 ms
// - watchdog register: code in bits 1:0, upper bits read zero
`default_nettype none
module psw_supervisor
  import psw_pkg::*;
#(
  parameter logic [CNT_W-1:0] HOLD_CYC = CNT_W'(RESET_HOLD_CYC),
  parameter logic [CNT_W-1:0] DEB_CYC = CNT_W'(DEBOUNCE_CYC),
  parameter logic [CNT_W-1:0] OSC_CYC = CNT_W'(OSC_START_CYC),
  parameter logic [CNT_W-1:0] WD_SHORT = CNT_W'(WD_SHORT_CYC),
  parameter logic [CNT_W-1:0] WD_MID = CNT_W'(WD_MID_CYC),
  parameter logic [CNT_W-1:0] WD_LONG = CNT_W'(WD_LONG_CYC)
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // supply monitor
  input wire logic power_fail,
  input wire logic oscillator_disable,
  // watchdog register port
  input wire logic wdreg_we,
  input wire logic [7:0] wdreg_wdata,
  output logic [7:0] wdreg_rdata,
  // watchdog strobe
  input wire logic watchdog_strobe,
  // processor reset line, open drain, active low
  input wire logic cpu_reset_n_in,
  output logic cpu_reset_n_out,
  output logic cpu_reset_n_oe,
  // SRAM selects
  input wire psw_sram_req_type sram_req,
  output psw_sram_sel_type sram_sel
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_PWR, ST_DEBOUNCE, ST_WAIT_REL, ST_HOLD
  } psw_state_type;

  typedef struct packed {
    psw_state_type state;
    logic [CNT_W-1:0] cnt;
    logic [1:0] td;
    logic line_prev;
    logic pwr_block;
    logic drive;
    logic [7:0] rdata;
  } psw_st_type;
  psw_st_type s_q;
  psw_st_type s_d;

  logic wd_expired;
  logic line_fall;
  logic line_rise;
  logic in_reset;

  // sampled wire level; our own drive also pulls it low
  assign line_fall = s_q.line_prev && !cpu_reset_n_in;
  assign line_rise = !s_q.line_prev && cpu_reset_n_in;
  assign in_reset = s_q.state != ST_IDLE;

  always_comb begin
    s_d = s_q;
    s_d.line_prev = cpu_reset_n_in;
    if (wdreg_we) begin
      s_d.td = wdreg_wdata[1:0];
    end
    s_d.rdata = {6'h00, s_d.td};
    unique case (s_q.state)
      ST_IDLE: begin
        if (line_fall) begin
          s_d.state = ST_DEBOUNCE;
          s_d.cnt = DEB_CYC;
        end else if (wd_expired) begin
          s_d.state = ST_HOLD;
          s_d.cnt = HOLD_CYC;
        end
      end
      ST_PWR: begin
        if (!power_fail) begin
          s_d.state = ST_HOLD;
          // the extra startup time covers a stopped oscillator
          s_d.cnt = oscillator_disable ? HOLD_CYC + OSC_CYC
                                       : HOLD_CYC;
        end
      end
      ST_DEBOUNCE: begin
        if (s_q.cnt <= CNT_W'(1)) begin
          // line stays pulled until we release and sample
          s_d.state = ST_WAIT_REL;
        end else begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end
      end
      ST_WAIT_REL: begin
        // first cycle here our drive is off; a high line is a release
        if (cpu_reset_n_in && s_q.drive) begin
          s_d.state = ST_WAIT_REL;
        end else if (cpu_reset_n_in && (line_rise || s_q.line_prev)) begin
          s_d.state = ST_HOLD;
          s_d.cnt = HOLD_CYC;
        end
      end
      ST_HOLD: begin
        if (s_q.cnt <= CNT_W'(1)) begin
          s_d.state = ST_IDLE;
          s_d.pwr_block = 1'b0;
        end else begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end
      end
      default: s_d.state = ST_IDLE;
    endcase
    if (power_fail) begin
      s_d.state = ST_PWR;
      s_d.pwr_block = 1'b1;
      s_d.cnt = HOLD_CYC;
    end
    // drive low in every reset state except while sampling for release
    s_d.drive = s_d.state != ST_IDLE && s_d.state != ST_WAIT_REL;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_q.state <= ST_PWR;
      s_q.cnt <= HOLD_CYC;
      s_q.td <= TD_RESET;
      s_q.line_prev <= 1'b1;
      s_q.pwr_block <= 1'b1;
      s_q.drive <= 1'b1;
      s_q.rdata <= WDREG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign cpu_reset_n_out = 1'b0;
  assign cpu_reset_n_oe = s_q.drive;
  assign wdreg_rdata = s_q.rdata;

  psw_wdog #(
    .SHORT_CYC(WD_SHORT),
    .MID_CYC(WD_MID),
    .LONG_CYC(WD_LONG)
  ) u_wdog (
    .clk(clk),
    .nrst(nrst),
    .timeout_code(s_q.td),
    .hold(in_reset || !cpu_reset_n_in),
    .watchdog_strobe(watchdog_strobe),
    .expired(wd_expired)
  );

  psw_sram_gate u_gate (
    .clk(clk),
    .nrst(nrst),
    .block(s_q.pwr_block || power_fail),
    .req(sram_req),
    .sel(sram_sel)
  );

  property p_pf_reset;
    @(posedge clk) disable iff (!nrst)
      power_fail |=> cpu_reset_n_oe;
  endproperty
  a_pf_reset: assert property (p_pf_reset)
    else $error("power fail did not assert reset");

  property p_hold_len;
    @(posedge clk) disable iff (!nrst)
      (s_q.state == ST_HOLD && !power_fail) |=> s_q.state == ST_HOLD ||
        (s_q.state == ST_IDLE && $past(s_q.cnt) <= CNT_W'(1));
  endproperty
  a_hold_len: assert property (p_hold_len)
    else $error("reset hold ended early");

  property p_osc_ext;
    @(posedge clk) disable iff (!nrst)
      (s_q.state == ST_PWR && !power_fail && oscillator_disable) |=>
        s_q.cnt == HOLD_CYC + OSC_CYC;
  endproperty
  a_osc_ext: assert property (p_osc_ext)
    else $error("oscillator startup not added to hold");

  property p_btn;
    @(posedge clk) disable iff (!nrst)
      (s_q.state == ST_IDLE && line_fall && !power_fail) |=>
        s_q.state == ST_DEBOUNCE && cpu_reset_n_oe && s_q.cnt == DEB_CYC;
  endproperty
  a_btn: assert property (p_btn)
    else $error("button edge not debounced");

  property p_wd_fire;
    @(posedge clk) disable iff (!nrst)
      (s_q.state == ST_IDLE && wd_expired && !line_fall && !power_fail)
        |=> s_q.state == ST_HOLD && s_q.cnt == HOLD_CYC ##1 cpu_reset_n_oe;
  endproperty
  a_wd_fire: assert property (p_wd_fire)
    else $error("watchdog expiry did not assert reset");

  property p_reg_read;
    @(posedge clk) disable iff (!nrst)
      wdreg_we |=> wdreg_rdata == {6'h00, $past(wdreg_wdata[1:0])};
  endproperty
  a_reg_read: assert property (p_reg_read)
    else $error("watchdog register readback wrong");

  property p_block_recover;
    @(posedge clk) disable iff (!nrst)
      (s_q.state == ST_HOLD && s_q.pwr_block) |=> sram_sel == 2'b11;
  endproperty
  a_block_recover: assert property (p_block_recover)
    else $error("sram access during power-up delay");

  property p_wd_held;
    @(posedge clk) disable iff (!nrst)
      in_reset |=> !wd_expired;
  endproperty
  a_wd_held: assert property (p_wd_held)
    else $error("watchdog ran during reset");
endmodule : psw_supervisor
`default_nettype wire

// [bench/psw_host_model.sv]
// Purpose: host side of the supervisor: strobe source and reset wire
// Assumes: wire has a pull-up; button shorts it low
// Notes: strobe only falls while strobe_on is high
`default_nettype none
module psw_host_model (
  // clock
  input wire logic clk,
  // bench control
  input wire logic strobe_on,
  input wire logic button,
  // device drive of the reset line
  input wire logic rst_drv,
  input wire logic rst_oe,
  // to the device
  output logic reset_wire,
  output logic strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] ph_q;
  initial begin
    ph_q = 5'h00;
    strobe = 1'b1;
  end
  // fall every 20 cycles, below the shortest period used
  always @(posedge clk) begin
    #1;
    ph_q = (ph_q == 5'h13) ? 5'h00 : ph_q + 5'h01;
    strobe = strobe_on ? (ph_q < 5'h0a) : 1'b1;
  end
  // open drain with pull-up, button wins
  assign reset_wire = !(rst_oe && !rst_drv) && !button;
endmodule : psw_host_model
`default_nettype wire

// [bench/psw_supervisor_tb.sv]
// Purpose: self-checking bench of the processor supervisor
// Assumes: shortened counts, host model on the reset wire
// Notes: durations checked with a few cycles of slack
`default_nettype none
module psw_supervisor_tb;
  import psw_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 32'h0000_0028;
  localparam int DEB = 32'h0000_0028;
  localparam int OSC = 32'h0000_0014;
  localparam int WS = 32'h0000_0032;
  localparam int WM = 32'h0000_0064;
  localparam int WL = 32'h0000_00c8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pf = 1'b0;
  logic osc = 1'b0;
  logic we = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic strobe, strobe_on, button, wire_n, drv, oe;
  psw_sram_req_type req;
  psw_sram_sel_type sel;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  initial begin
    strobe_on = 1'b1;
    button = 1'b0;
    req = 3'h7;
  end
  always #2 clk = ~clk;
  psw_supervisor #(.HOLD_CYC(CNT_W'(HOLD)), .DEB_CYC(CNT_W'(DEB)),
    .OSC_CYC(CNT_W'(OSC)), .WD_SHORT(CNT_W'(WS)), .WD_MID(CNT_W'(WM)),
    .WD_LONG(CNT_W'(WL))) dut (.clk(clk), .nrst(nrst), .power_fail(pf),
    .oscillator_disable(osc), .wdreg_we(we), .wdreg_wdata(wdata),
    .wdreg_rdata(rdata), .watchdog_strobe(strobe), .cpu_reset_n_in(wire_n),
    .cpu_reset_n_out(drv), .cpu_reset_n_oe(oe), .sram_req(req),
    .sram_sel(sel));
  psw_host_model host (.clk(clk), .strobe_on(strobe_on), .button(button),
    .rst_drv(drv), .rst_oe(oe), .reset_wire(wire_n), .strobe(strobe));
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // a hang must still reach the verdict
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step
  task automatic wait_oe(input logic v, output int k);
    k = 0;
    while (oe !== v && k < 2000) begin
      step(1);
      k++;
    end
  endtask : wait_oe
  task automatic wr(input logic [7:0] d);
    we = 1'b1;
    wdata = d;
    step(1);
    we = 1'b0;
    step(1);
  endtask : wr
  task automatic t_powerup();
    check(rdata, 8'h03);
    check(sel, 2'h3);
    check(oe, 1'b1);
    wait_oe(1'b0, n);
    check(n >= HOLD - 3 && n <= HOLD + 3, 1'b1);
    for (int i = 0; i < 8; i++) begin
      req = psw_sram_req_type'(i[2:0]);
      step(2);
      check(sel, {i[2] | i[1], i[2] | i[0]});
    end
  endtask : t_powerup
  task automatic t_power_fail(input logic o);
    int e;
    e = HOLD + (o ? OSC : 0);
    osc = o;
    req = 3'h0;
    pf = 1'b1;
    step(2);
    check(oe, 1'b1);
    check(sel, 2'h3);
    step(10);
    pf = 1'b0;
    step(HOLD / 2);
    check(sel, 2'h3);
    wait_oe(1'b0, n);
    n = n + HOLD / 2;
    check(n >= e - 2 && n <= e + 4, 1'b1);
    step(2);
    check(sel, 2'h0);
    osc = 1'b0;
  endtask : t_power_fail
  task automatic t_wdog(input logic [7:0] code, input int per);
    wr(code);
    check(rdata, code);
    pf = 1'b1;
    step(2);
    pf = 1'b0;
    wait_oe(1'b0, n);
    strobe_on = 1'b0;
    wait_oe(1'b1, n);
    check(n >= per && n <= per + 4, 1'b1);
    wait_oe(1'b0, n);
    check(n >= HOLD - 1 && n <= HOLD + 3, 1'b1);
    strobe_on = 1'b1;
  endtask : t_wdog
  task automatic t_wd_off();
    wr(8'h01);
    step(300);
    check(oe, 1'b0);
    wr(8'hff);
    check(rdata, 8'h03);
    wr(8'h00);
    check(rdata, 8'h00);
    strobe_on = 1'b0;
    step(3 * WL);
    check(oe, 1'b0);
    strobe_on = 1'b1;
    wr(8'h01);
  endtask : t_wd_off
  // strobe off: any countdown leaking through the button cycle shows
  task automatic t_button();
    strobe_on = 1'b0;
    button = 1'b1;
    step(3);
    check(oe, 1'b1);
    step(DEB / 2);
    check(oe, 1'b1);
    wait_oe(1'b0, n);
    n = n + DEB / 2 + 3;
    check(n >= DEB - 1 && n <= DEB + 4, 1'b1);
    step(20);
    check(oe, 1'b0);
    button = 1'b0;
    step(3);
    check(oe, 1'b1);
    wait_oe(1'b0, n);
    check(n >= HOLD - 4 && n <= HOLD + 2, 1'b1);
    wait_oe(1'b1, n);
    check(n >= WS && n <= WS + 4, 1'b1);
    strobe_on = 1'b1;
    wait_oe(1'b0, n);
  endtask : t_button
  initial begin
    step(2);
    nrst = 1'b1;
    step(1);
    t_powerup();
    t_power_fail(1'b0);
    t_power_fail(1'b1);
    t_wdog(8'h01, WS);
    t_wdog(8'h02, WM);
    t_wdog(8'h03, WL);
    t_wd_off();
    t_button();
    print_verdict();
  end
endmodule : psw_supervisor_tb
`default_nettype wire
